// File: rtl/bcw_mem.sv
/*
 bcw_mem: seven 24-bit configuration words, registered read ports.
 Assumes reset stands for an erase of the array to all ones.
*/
`timescale 1ns/100ps
module bcw_mem
   import bcw_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // store port
   bcw_mem_if.mem   bus
);
   logic [WORD_W-1:0] mem_q [NWORDS];
   logic [WORD_W-1:0] mem_d [NWORDS];
   logic [WORD_W-1:0] ra_q, ra_d, rb_q, rb_d;

   always_comb
   begin
      mem_d = mem_q;
      if (bus.we) mem_d[bus.waddr] = bus.wdata;
      // out-of-range index reads as erased
      ra_d = (bus.ra_addr < IDX_W'(NWORDS)) ? mem_q[bus.ra_addr] : ERASED;
      rb_d = (bus.rb_addr < IDX_W'(NWORDS)) ? mem_q[bus.rb_addr] : ERASED;
   end

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         for (int i = 0; i < NWORDS; i++) mem_q[i] <= ERASED;
         ra_q <= ERASED;
         rb_q <= ERASED;
      end
      else
      begin
         mem_q <= mem_d;
         ra_q  <= ra_d;
         rb_q  <= rb_d;
      end
   end

   assign bus.ra_data = ra_q;
   assign bus.rb_data = rb_q;
endmodule // bcw_mem

// File: rtl/bcw_mem_if.sv
/*
 bcw_mem_if: write port and two read ports of the configuration store.
 Assumes the controller only presents indices below NWORDS for writes.
*/
`timescale 1ns/100ps
interface bcw_mem_if;
   import bcw_pkg::*;
   logic              we;
   logic [IDX_W-1:0]  waddr;
   logic [WORD_W-1:0] wdata;
   logic [IDX_W-1:0]  ra_addr;
   logic [IDX_W-1:0]  rb_addr;
   logic [WORD_W-1:0] ra_data;
   logic [WORD_W-1:0] rb_data;
   modport ctrl (output we, waddr, wdata, ra_addr, rb_addr, input ra_data, rb_data);
   modport mem  (input we, waddr, wdata, ra_addr, rb_addr, output ra_data, rb_data);
endinterface

// File: rtl/bcw_once.sv
/*
 bcw_once: one programmed flag per configuration word.
 Assumes a set request carries an index below NWORDS.
*/
`timescale 1ns/100ps
module bcw_once
   import bcw_pkg::*;
(
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_arst_n,
   // set request
   input  wire logic              i_set,
   input  wire logic [IDX_W-1:0]  i_idx,
   // flags
   output logic      [NWORDS-1:0] o_programmed
);
   logic [NWORDS-1:0] flag_q, flag_d;

   for (genvar g = 0; g < NWORDS; g++)
   begin : g_flag
      assign flag_d[g] = flag_q[g] | (i_set && (i_idx == IDX_W'(g)));
   end

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n) flag_q <= '0;
      else flag_q <= flag_d;
   end

   assign o_programmed = flag_q;
endmodule // bcw_once

// File: rtl/bcw_pkg.sv
/*
 bcw_pkg: constants, types and helpers shared by the boot configuration
 word bank. Assumes word indices double as register bus addresses.
*/
package bcw_pkg;
   localparam int unsigned WORD_W = 24;
   localparam int unsigned NWORDS = 7;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned IDX_W  = 3;
   localparam int unsigned HALF_W = 16;

   // word indices, equal to their bus addresses
   localparam logic [IDX_W-1:0]  IDX_POR  = 3'h0;
   localparam logic [IDX_W-1:0]  IDX_ICD  = 3'h1;
   localparam logic [IDX_W-1:0]  IDX_IVTL = 3'h2;
   localparam logic [IDX_W-1:0]  IDX_IVTH = 3'h3;
   localparam logic [IDX_W-1:0]  IDX_CNTL = 3'h4;
   localparam logic [IDX_W-1:0]  IDX_CNTH = 3'h5;
   localparam logic [IDX_W-1:0]  IDX_DMT  = 3'h6;
   localparam logic [ADDR_W-1:0] ADDR_LAST_WORD = 4'h6;
   localparam logic [ADDR_W-1:0] ADDR_STATUS    = 4'h7;

   // erased value and programmable bit masks
   localparam logic [WORD_W-1:0] ERASED    = 24'hFF_FFFF;
   localparam logic [WORD_W-1:0] MASK_POR  = 24'h00_0470;
   localparam logic [WORD_W-1:0] MASK_ICD  = 24'h00_00A3;
   localparam logic [WORD_W-1:0] MASK_HALF = 24'h00_FFFF;
   localparam logic [WORD_W-1:0] MASK_DMT  = 24'h00_0001;

   // field positions
   localparam int unsigned BIT_SELFTEST_DIS = 6;
   localparam int unsigned BIT_SCAN_EN      = 5;
   localparam int unsigned BIT_CHAN_LSB     = 0;
   localparam int unsigned BIT_DEADMAN_DIS  = 0;
   localparam int unsigned STAT_LOADED      = 7;
   localparam int unsigned STAT_REJECT      = 8;
   localparam int unsigned STAT_POR         = 9;

   // debug channel codes
   localparam logic [1:0] CHAN_PAIR1 = 2'h3;
   localparam logic [1:0] CHAN_PAIR2 = 2'h2;
   localparam logic [1:0] CHAN_PAIR3 = 2'h1;

   typedef enum logic [1:0] {BCW_ST_LOAD = 2'h1, BCW_ST_RUN = 2'h2} bcw_state_type;

   function automatic logic [WORD_W-1:0] word_mask(input logic [IDX_W-1:0] idx);
      if (idx == IDX_POR) return MASK_POR;
      else if (idx == IDX_ICD) return MASK_ICD;
      else if (idx == IDX_DMT) return MASK_DMT;
      else return MASK_HALF;
   endfunction

   function automatic logic [2:0] chan_decode(input logic [1:0] ch);
      if (ch == CHAN_PAIR1) return 3'h1;
      else if (ch == CHAN_PAIR2) return 3'h2;
      else if (ch == CHAN_PAIR3) return 3'h4;
      else return 3'h0;
   endfunction
endpackage

// File: rtl/bcw_top.sv
/*
 bcw_top: program-once boot configuration words for self-test, scan port,
 debug channel and deadman timer, with a plain register port. Assumes
 i_por_reset comes from the reset controller on i_clk, settles before
 i_arst_n falls and stays stable for the first cycles after release.
*/
`timescale 1ns/100ps
// Summary of operation
// - a zero self-test disable bit requests the memory self-test, a one skips it.
// - the self-test request is raised only after a power-on reset.
// - unimplemented bits of every word read back as one.
// - the scan enable bit turns the test port on when one and off when zero.
// - channel codes 11, 10 and 01 select programming pin pairs 1, 2 and 3.
// - the window interval joins the low halves of its low and high words.
// - the count timeout joins the low halves of its low and high words.
// - the deadman disable bit stops the timer when one and enables it when zero.
// - words read back, program only once and read as ones while erased.
module bcw_top
   import bcw_pkg::*;
(
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_arst_n,
   input  wire logic              i_por_reset,
   // register port
   input  wire logic [ADDR_W-1:0] i_reg_addr,
   input  wire logic [WORD_W-1:0] i_reg_wdata,
   input  wire logic              i_reg_wr,
   input  wire logic              i_reg_rd,
   output logic      [WORD_W-1:0] o_reg_rdata,
   // configuration outputs
   output logic                   o_cfg_loaded,
   output logic                   o_selftest_start,
   output logic                   o_scan_port_enable,
   output logic      [1:0]        o_debug_channel_select,
   output logic      [2:0]        o_debug_pair_sel,
   output logic      [31:0]       o_deadman_window_interval,
   output logic      [31:0]       o_deadman_count_timeout,
   output logic                   o_deadman_enable
);
   bcw_mem_if mem_if ();

   logic [NWORDS-1:0] programmed;
   logic              wr_word;
   logic              wr_acc;
   logic              wr_rej;
   logic              wr_stat;
   logic [IDX_W-1:0]  wr_idx;
   logic [HALF_W-1:0] ra_half;
   logic              store_rst_n;

   bcw_state_type     state_q, state_d;
   logic [IDX_W-1:0]  rd_idx_q, rd_idx_d;
   logic              issuing_q, issuing_d;
   logic              ld_vld_q, ld_vld_d;
   logic [IDX_W-1:0]  ld_idx_q, ld_idx_d;
   logic [WORD_W-1:0] shadow_q [NWORDS];
   logic [WORD_W-1:0] shadow_d [NWORDS];
   logic              por_q, por_d;
   logic              loaded_q, loaded_d;
   logic              selftest_q, selftest_d;
   logic [2:0]        pair_q, pair_d;
   logic              reject_q, reject_d;
   logic              rd_word_q, rd_word_d;
   logic              rd_stat_q, rd_stat_d;
   logic [IDX_W-1:0]  ridx_q, ridx_d;
   logic [WORD_W-1:0] stat_q, stat_d;

   function automatic logic addr_is_word(input logic [ADDR_W-1:0] a);
      return a <= ADDR_LAST_WORD;
   endfunction

   // store and flags survive warm resets, only a power-on reset erases them
   // limitation: a por change while i_arst_n is low also erases
   assign store_rst_n = i_arst_n | ~i_por_reset;

   bcw_mem u_mem
   (
      .i_clk    (i_clk),
      .i_arst_n (store_rst_n),
      .bus      (mem_if)
   );

   bcw_once u_once
   (
      .i_clk        (i_clk),
      .i_arst_n     (store_rst_n),
      .i_set        (wr_acc),
      .i_idx        (wr_idx),
      .o_programmed (programmed)
   );

   // write decode; words are locked while the loader runs
   always_comb
   begin
      wr_idx  = i_reg_addr[IDX_W-1:0];
      wr_word = 1'b0;
      wr_stat = 1'b0;
      if (i_reg_wr && addr_is_word(i_reg_addr)) wr_word = 1'b1;
      else if (i_reg_wr && (i_reg_addr == ADDR_STATUS)) wr_stat = 1'b1;
      wr_acc  = wr_word && (state_q == BCW_ST_RUN) && !programmed[wr_idx];
      wr_rej  = wr_word && !wr_acc;
   end

   always_comb
   begin
      mem_if.we      = wr_acc;
      mem_if.waddr   = wr_idx;
      mem_if.wdata   = i_reg_wdata | ~word_mask(wr_idx);
      mem_if.rb_addr = wr_idx;
      mem_if.ra_addr = rd_idx_q;
   end

   // status and read path
   always_comb
   begin
      rd_word_d = 1'b0;
      rd_stat_d = 1'b0;
      if (i_reg_rd && addr_is_word(i_reg_addr)) rd_word_d = 1'b1;
      else if (i_reg_rd && (i_reg_addr == ADDR_STATUS)) rd_stat_d = 1'b1;
      ridx_d = wr_idx;
      stat_d = '0;
      stat_d[NWORDS-1:0]  = programmed;
      stat_d[STAT_LOADED] = loaded_q;
      stat_d[STAT_REJECT] = reject_q;
      stat_d[STAT_POR]    = por_q;
      // set beats a same-cycle clear
      if (wr_rej) reject_d = 1'b1;
      else if (wr_stat && i_reg_wdata[STAT_REJECT]) reject_d = 1'b0;
      else reject_d = reject_q;
   end

   always_comb
   begin
      if (rd_word_q) o_reg_rdata = mem_if.rb_data;
      else if (rd_stat_q) o_reg_rdata = stat_q;
      else o_reg_rdata = '0;
   end

   // loader: one read issued per cycle, data captured a cycle later
   always_comb
   begin
      state_d    = state_q;
      rd_idx_d   = rd_idx_q;
      issuing_d  = issuing_q;
      ld_vld_d   = 1'b0;
      ld_idx_d   = rd_idx_q;
      shadow_d   = shadow_q;
      por_d      = por_q;
      loaded_d   = loaded_q;
      selftest_d = 1'b0;
      pair_d     = pair_q;
      case (state_q)
         BCW_ST_LOAD:
         begin
            ld_vld_d = issuing_q;
            if (issuing_q && (rd_idx_q == IDX_DMT)) issuing_d = 1'b0;
            else if (issuing_q) rd_idx_d = rd_idx_q + 3'h1;
            // reset source caught once per load
            if (issuing_q && (rd_idx_q == IDX_POR)) por_d = i_por_reset;
            if (ld_vld_q) shadow_d[ld_idx_q] = mem_if.ra_data;
            if (ld_vld_q && (ld_idx_q == IDX_DMT))
            begin
               state_d  = BCW_ST_RUN;
               loaded_d = 1'b1;
               selftest_d = por_q && !shadow_q[IDX_POR][BIT_SELFTEST_DIS];
               pair_d = chan_decode(shadow_q[IDX_ICD][BIT_CHAN_LSB +: 2]);
            end
         end
         BCW_ST_RUN:
         begin
            state_d = BCW_ST_RUN;
         end
         default:
         begin
            state_d = BCW_ST_LOAD;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         state_q    <= BCW_ST_LOAD;
         rd_idx_q   <= IDX_POR;
         issuing_q  <= 1'b1;
         ld_vld_q   <= 1'b0;
         ld_idx_q   <= IDX_POR;
         for (int i = 0; i < NWORDS; i++) shadow_q[i] <= ERASED;
         por_q      <= 1'b0;
         loaded_q   <= 1'b0;
         selftest_q <= 1'b0;
         pair_q     <= 3'h0;
         reject_q   <= 1'b0;
         rd_word_q  <= 1'b0;
         rd_stat_q  <= 1'b0;
         ridx_q     <= IDX_POR;
         stat_q     <= '0;
      end
      else
      begin
         state_q    <= state_d;
         rd_idx_q   <= rd_idx_d;
         issuing_q  <= issuing_d;
         ld_vld_q   <= ld_vld_d;
         ld_idx_q   <= ld_idx_d;
         shadow_q   <= shadow_d;
         por_q      <= por_d;
         loaded_q   <= loaded_d;
         selftest_q <= selftest_d;
         pair_q     <= pair_d;
         reject_q   <= reject_d;
         rd_word_q  <= rd_word_d;
         rd_stat_q  <= rd_stat_d;
         ridx_q     <= ridx_d;
         stat_q     <= stat_d;
      end
   end

   assign o_cfg_loaded           = loaded_q;
   assign o_selftest_start       = selftest_q;
   assign o_scan_port_enable     = shadow_q[IDX_ICD][BIT_SCAN_EN];
   assign o_debug_channel_select = shadow_q[IDX_ICD][BIT_CHAN_LSB +: 2];
   assign o_debug_pair_sel       = pair_q;
   assign o_deadman_window_interval = {shadow_q[IDX_IVTH][HALF_W-1:0], shadow_q[IDX_IVTL][HALF_W-1:0]};
   assign o_deadman_count_timeout   = {shadow_q[IDX_CNTH][HALF_W-1:0], shadow_q[IDX_CNTL][HALF_W-1:0]};
   assign o_deadman_enable       = !shadow_q[IDX_DMT][BIT_DEADMAN_DIS];

   // checks
   assign ra_half = mem_if.ra_data[HALF_W-1:0];

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_arst_n);

   a_selftest_decision:
   assert property ($rose(loaded_q) |-> (selftest_q == (por_q && !shadow_q[IDX_POR][BIT_SELFTEST_DIS])))
      else $error("self-test request does not match disable bit");

   a_selftest_single_pulse:
   assert property (selftest_q |=> !selftest_q && $stable(loaded_q))
      else $error("self-test request longer than one cycle");

   a_selftest_por_only:
   assert property (selftest_q |-> por_q && loaded_q)
      else $error("self-test requested without power-on reset");

   a_unimpl_read_ones:
   assert property (rd_word_q |-> ((o_reg_rdata | word_mask(ridx_q)) == ERASED))
      else $error("unimplemented bit read as zero");

   a_scan_port_load:
   assert property (ld_vld_q && (ld_idx_q == IDX_ICD) |=> o_scan_port_enable == $past(mem_if.ra_data[BIT_SCAN_EN]))
      else $error("scan enable not taken from debug word");

   a_pair_matches_code:
   assert property (loaded_q |-> o_debug_pair_sel == chan_decode(o_debug_channel_select))
      else $error("debug pin pair does not match channel code");

   a_window_high_half:
   assert property (ld_vld_q && (ld_idx_q == IDX_IVTH) |=> o_deadman_window_interval[31:16] == $past(ra_half))
      else $error("window interval high half wrong");

   a_count_low_half:
   assert property (ld_vld_q && (ld_idx_q == IDX_CNTL) |=> o_deadman_count_timeout[15:0] == $past(ra_half))
      else $error("count timeout low half wrong");

   a_deadman_enable_load:
   assert property (ld_vld_q && (ld_idx_q == IDX_DMT) |=> o_deadman_enable == !$past(mem_if.ra_data[0]))
      else $error("deadman enable not inverse of disable bit");

   a_second_write_blocked:
   assert property (wr_acc ##1 (i_reg_wr && (i_reg_addr == $past(i_reg_addr))) |-> !wr_acc && wr_rej)
      else $error("configuration word programmed twice");

   a_load_time_bound:
   assert property ($rose(i_arst_n) |-> ##[1:10] loaded_q)
      else $error("configuration load did not finish");

   a_config_held:
   assert property (loaded_q && $past(loaded_q) |-> $stable(o_deadman_window_interval) && $stable(o_deadman_count_timeout)
                    && $stable(o_scan_port_enable) && $stable(o_deadman_enable) && $stable(o_debug_pair_sel))
      else $error("configuration changed before reset");

   a_rdata_idle_zero:
   assert property (!rd_word_q && !rd_stat_q |-> o_reg_rdata == '0)
      else $error("read data not zero outside a read answer");

   a_early_write_refused:
   assert property (wr_word && !loaded_q |-> wr_rej && !mem_if.we)
      else $error("word write accepted before the load finished");

   a_reject_sticky:
   assert property (wr_rej |=> reject_q)
      else $error("refused write did not raise the reject flag");

   a_store_ones_forced:
   assert property (mem_if.we |-> (mem_if.wdata | word_mask(mem_if.waddr)) == ERASED)
      else $error("unimplemented bit stored as zero");

   a_pair_one_hot:
   assert property ($onehot0(o_debug_pair_sel))
      else $error("more than one pin pair selected");

   a_window_low_half:
   assert property (ld_vld_q && (ld_idx_q == IDX_IVTL) |=> o_deadman_window_interval[15:0] == $past(ra_half))
      else $error("window interval low half wrong");

   a_count_high_half:
   assert property (ld_vld_q && (ld_idx_q == IDX_CNTH) |=> o_deadman_count_timeout[31:16] == $past(ra_half))
      else $error("count timeout high half wrong");

   c_warm_reload:
   cover property ($rose(loaded_q) && !por_q && programmed[IDX_POR]);

   c_selftest_started:
   cover property (selftest_q);

   c_write_rejected:
   cover property (wr_rej ##1 rd_stat_q);

   c_program_then_read:
   cover property (wr_acc ##1 rd_word_q);

   c_load_without_selftest:
   cover property ($rose(loaded_q) && !selftest_q);
endmodule // bcw_top

// File: test/tb_bcw_top.sv
/*
 tb_bcw_top: self-checking bench for the boot configuration word bank.
 Assumes a 50 MHz clock, the register port timing of bcw_top and that
 a reset taken with i_por_reset high erases the store, others keep it.
*/
`timescale 1ns/100ps
module tb_bcw_top;
   import bcw_pkg::*;

   logic              i_clk;
   logic              i_arst_n;
   logic              i_por_reset;
   logic [ADDR_W-1:0] i_reg_addr;
   logic [WORD_W-1:0] i_reg_wdata;
   logic              i_reg_wr;
   logic              i_reg_rd;
   logic [WORD_W-1:0] o_reg_rdata;
   logic              o_cfg_loaded;
   logic              o_selftest_start;
   logic              o_scan_port_enable;
   logic [1:0]        o_debug_channel_select;
   logic [2:0]        o_debug_pair_sel;
   logic [31:0]       o_deadman_window_interval;
   logic [31:0]       o_deadman_count_timeout;
   logic              o_deadman_enable;
   int                miscompares;
   int                n_tests;
   int                st_pulses;

   // upper data bits of word 2 are set on purpose, they must be dropped
   // reserved bits kept, channel code never 00
   localparam logic [WORD_W-1:0] PROG_DATA [7] = '{24'h00_0430, 24'h00_0081, 24'h12_5678, 24'h00_1234,
                                                   24'h00_BEEF, 24'h00_CAFE, 24'h00_0000};
   localparam logic [WORD_W-1:0] PROG_READ [7] = '{24'hFF_FFBF, 24'hFF_FFDD, 24'hFF_5678, 24'hFF_1234,
                                                   24'hFF_BEEF, 24'hFF_CAFE, 24'hFF_FFFE};

   bcw_top dut (
      .i_clk                     (i_clk),
      .i_arst_n                  (i_arst_n),
      .i_por_reset               (i_por_reset),
      .i_reg_addr                (i_reg_addr),
      .i_reg_wdata               (i_reg_wdata),
      .i_reg_wr                  (i_reg_wr),
      .i_reg_rd                  (i_reg_rd),
      .o_reg_rdata               (o_reg_rdata),
      .o_cfg_loaded              (o_cfg_loaded),
      .o_selftest_start          (o_selftest_start),
      .o_scan_port_enable        (o_scan_port_enable),
      .o_debug_channel_select    (o_debug_channel_select),
      .o_debug_pair_sel          (o_debug_pair_sel),
      .o_deadman_window_interval (o_deadman_window_interval),
      .o_deadman_count_timeout   (o_deadman_count_timeout),
      .o_deadman_enable          (o_deadman_enable)
   );

   initial
   begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end

   // erased self-test disable bit must never let a pulse through
   always @(posedge i_clk)
   begin
      if (o_selftest_start !== 1'b0 && i_arst_n === 1'b1)
         st_pulses++;
   end

   task automatic summarize;
      $display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
      if (miscompares == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
      @(posedge i_clk);
      i_reg_addr  <= a;
      i_reg_wdata <= d;
      i_reg_wr    <= 1'b1;
      @(posedge i_clk);
      i_reg_wr    <= 1'b0;
   endtask

   task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] exp, input string what);
      @(posedge i_clk);
      i_reg_addr <= a;
      i_reg_rd   <= 1'b1;
      @(posedge i_clk);
      i_reg_rd   <= 1'b0;
      @(negedge i_clk);
      chk({8'h00, o_reg_rdata}, {8'h00, exp}, what);
   endtask

   // cleared loaded flag, pin pair and read data must show while reset is held; erase high wipes the store
   task automatic do_reset(input logic erase, input logic por);
      st_pulses = 0;
      @(posedge i_clk);
      // por settles before reset asserts, so no false erase
      i_por_reset <= erase;
      i_arst_n    <= 1'b0;
      repeat (9) @(posedge i_clk);
      @(negedge i_clk);
      chk({31'h0, o_cfg_loaded}, 32'h0000_0000, "loaded in reset");
      chk({29'h0, o_debug_pair_sel}, 32'h0000_0000, "pair in reset");
      chk({8'h00, o_reg_rdata}, 32'h0000_0000, "rdata in reset");
      @(posedge i_clk);
      i_arst_n    <= 1'b1;
      i_por_reset <= por;
   endtask

   // load timing, erased fields and early write refusal
   task automatic t_boot(input logic por, input logic [WORD_W-1:0] stat);
      int n;
      do_reset(por, por);
      reg_wr(4'h2, 24'h00_0000);
      n = 2;
      @(negedge i_clk);
      while (o_cfg_loaded !== 1'b1 && n < 20)
      begin
         @(negedge i_clk);
         n++;
      end
      chk(32'(n), 32'd8, "load done cycle");
      chk({31'h0, o_scan_port_enable}, 32'h0000_0001, "scan enable erased");
      chk({30'h0, o_debug_channel_select}, 32'h0000_0003, "channel erased");
      chk({29'h0, o_debug_pair_sel}, 32'h0000_0001, "pair 1 selected");
      chk(o_deadman_window_interval, 32'hFFFF_FFFF, "window erased");
      chk(o_deadman_count_timeout, 32'hFFFF_FFFF, "count erased");
      chk({31'h0, o_deadman_enable}, 32'h0000_0000, "deadman off");
      reg_rd(ADDR_STATUS, stat, "status after boot");
      for (int i = 0; i < 7; i++)
         reg_rd(4'(i), 24'hFF_FFFF, "erased word");
      reg_wr(ADDR_STATUS, 24'h00_0100);
      reg_rd(ADDR_STATUS, stat & 24'h00_02FF, "reject cleared");
      chk(32'(st_pulses), 32'd0, "no self-test pulse");
   endtask

   // program once, forced ones, outputs held
   task automatic t_program;
      for (int i = 0; i < 6; i++)
         reg_wr(4'(i), PROG_DATA[i]);
      reg_rd(ADDR_STATUS, 24'h00_02BF, "six programmed");
      // back-to-back writes to one word, only the first may land
      @(posedge i_clk);
      i_reg_addr  <= 4'h6;
      i_reg_wdata <= PROG_DATA[6];
      i_reg_wr    <= 1'b1;
      @(posedge i_clk);
      i_reg_wdata <= 24'h00_0001;
      @(posedge i_clk);
      i_reg_wr    <= 1'b0;
      for (int i = 0; i < 7; i++)
         reg_rd(4'(i), PROG_READ[i], "programmed word");
      reg_rd(ADDR_STATUS, 24'h00_03FF, "double write flagged");
      reg_wr(ADDR_STATUS, 24'h00_0100);
      reg_rd(ADDR_STATUS, 24'h00_02FF, "all programmed");
      reg_wr(4'h3, 24'h00_0000);
      reg_rd(4'h3, 24'hFF_1234, "second write dropped");
      reg_wr(4'h0, 24'h00_0030);
      reg_rd(4'h0, 24'hFF_FFBF, "second write dropped");
      reg_rd(ADDR_STATUS, 24'h00_03FF, "reject flagged");
      chk({31'h0, o_scan_port_enable}, 32'h0000_0001, "scan held");
      chk(o_deadman_window_interval, 32'hFFFF_FFFF, "window held");
      chk({31'h0, o_deadman_enable}, 32'h0000_0000, "deadman held");
   endtask

   // programmed words reach the outputs after a reset that keeps the store
   task automatic t_reload(input logic por);
      do_reset(1'b0, por);
      repeat (8) @(negedge i_clk);
      chk({31'h0, o_cfg_loaded}, 32'h0000_0000, "loaded too early");
      @(negedge i_clk);
      chk({31'h0, o_cfg_loaded}, 32'h0000_0001, "loaded in cycle 8");
      chk({31'h0, o_selftest_start}, {31'h0, por}, "self-test on power-on only");
      chk({31'h0, o_scan_port_enable}, 32'h0000_0000, "scan disabled");
      chk({29'h0, o_debug_pair_sel}, 32'h0000_0004, "pair 3 selected");
      chk(o_deadman_window_interval, 32'h1234_5678, "window joined");
      chk(o_deadman_count_timeout, 32'hCAFE_BEEF, "count joined");
      chk({31'h0, o_deadman_enable}, 32'h0000_0001, "deadman on");
      reg_rd(ADDR_STATUS, {14'h0, por, 9'h0FF}, "status after reload");
      reg_wr(4'h2, 24'h00_0000);
      reg_rd(4'h2, PROG_READ[2], "word kept over reset");
      reg_rd(ADDR_STATUS, {14'h0, por, 9'h1FF}, "reprogram refused");
      chk(32'(st_pulses), {31'h0, por}, "self-test pulse count");
   endtask

   // unmapped addresses and idle read data
   task automatic t_bus_edges;
      for (int a = 8; a < 16; a++)
         reg_rd(4'(a), 24'h00_0000, "unmapped read");
      reg_wr(4'h9, 24'hFF_FFFF);
      reg_rd(ADDR_STATUS, 24'h00_03FF, "unmapped write ignored");
      @(negedge i_clk);
      chk({8'h00, o_reg_rdata}, 32'h0000_0000, "idle rdata");
   endtask

   initial
   begin
      #(20 * 5000);
      miscompares++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      summarize();
   end

   initial
   begin
      i_arst_n    = 1'b0;
      i_por_reset = 1'b1;
      i_reg_addr  = 4'h0;
      i_reg_wdata = 24'h00_0000;
      i_reg_wr    = 1'b0;
      i_reg_rd    = 1'b0;
      miscompares = 0;
      n_tests     = 0;
      st_pulses   = 0;
      t_boot(1'b1, 24'h00_0380);
      t_program();
      t_bus_edges();
      t_reload(1'b0);
      t_reload(1'b1);
      t_boot(1'b1, 24'h00_0380);
      summarize();
   end
endmodule // tb_bcw_top
